// ===== design/budget_pkg.sv
package budget_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned ENTRY_COUNT = 10;
   localparam logic [11:0] OFF_CAP_HEADER = 12'h280;
   localparam logic [11:0] OFF_SELECT = 12'h284;
   localparam logic [11:0] OFF_READOUT = 12'h288;
   localparam logic [11:0] OFF_ENTRY_BASE = 12'h300;
   localparam logic [11:0] OFF_UNLOCK = 12'h340;
   localparam logic [11:0] OFF_HEADER_LOCK = 12'h344;
   localparam logic [31:0] HEADER_RESET = 32'h0000_0000;
   localparam logic [7:0] SELECT_RESET = 8'h00;
   localparam logic [3:0] ENTRY_MAX = 4'h9;
   localparam int unsigned SEL_W = 8;
   localparam int unsigned ID_LSB = 0;
   localparam int unsigned ID_W = 16;
   localparam int unsigned VER_LSB = 16;
   localparam int unsigned VER_W = 4;
   localparam int unsigned LINK_LSB = 20;
   localparam int unsigned LINK_W = 12;
   localparam logic [15:0] CAP_ID_POWER = 16'h0004;
   localparam logic [3:0] CAP_VERSION_ONE = 4'h1;

   typedef struct packed {
      logic [11:0] following_structure_link;
      logic [3:0] structure_version;
      logic [15:0] capability_identifier;
   } cap_header_s;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } wb_req_s;
endpackage

// ===== design/budget_entry_store.sv
`timescale 1ns/1ns
module budget_entry_store #(
   parameter int unsigned ENTRIES = budget_pkg::ENTRY_COUNT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic unlock_i,
   input wire logic wr_en_i,
   input wire logic [3:0] wr_idx_i,
   input wire logic [3:0] wr_sel_i,
   input wire logic [31:0] wr_data_i,
   input wire logic [7:0] rd_sel_i,
   output logic [31:0] rd_data_o,
   output logic [31:0] sel_data_o
);
   logic [31:0] entry [ENTRIES];
   logic sel_in_range;
   logic [31:0] next_sel_data;

   // Stored words clear on the fundamental reset so the readout starts at zero
   genvar g;
   generate
      for (g = 0; g < ENTRIES; g++) begin : gen_entry
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               entry[g] <= '0;
            end else if (wr_en_i && unlock_i && wr_idx_i == 4'(g)) begin // [R8]
               for (int b = 0; b < 4; b++) begin
                  if (wr_sel_i[b]) begin
                     entry[g][8*b +: 8] <= wr_data_i[8*b +: 8];
                  end
               end
            end
         end
      end
   endgenerate

   assign sel_in_range = rd_sel_i <= {4'h0, budget_pkg::ENTRY_MAX}; // [R5]
   assign next_sel_data = sel_in_range ? entry[rd_sel_i[3:0]] : 32'h0000_0000; // [R6]
   assign rd_data_o = (wr_idx_i < 4'(ENTRIES)) ? entry[wr_idx_i] : 32'h0000_0000; // [R7]

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_data_o <= 32'h0000_0000;
      end else begin
         sel_data_o <= next_sel_data;
      end
   end
endmodule

// ===== design/power_budget_capability_regs.sv
`timescale 1ns/1ns
// What this block does
// R1: Header identifier bits 15:0 is 0x4 for power budgeting; lock-gated writes.
// R2: Header bits 19:16 hold structure version; 1 means first version.
// R3: Software or serial memory loads identifier and version; reset is zero. This block has no serial memory load, only bus writes.
// R4: Eight-bit read-write selector, reset zero, picks the readout entry.
// R5: Selector above 9 makes readout return zero.
// R6: Readout is 32-bit read-only: chosen entry or zero.
// R7: Ten 32-bit stored entries live from offset 0x300.
// R8: Stored entries take writes only while the unlock bit is set.
// R9: Header fields reset to zero; writes only when header lock is open.
module power_budget_capability_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [31:0] budget_readout_o
);
   budget_pkg::cap_header_s budget_cap_header;
   logic [7:0] budget_entry_selector;
   logic budget_entry_unlock;
   logic header_write_open;
   logic ack;
   logic [31:0] rdata;

   wire req = wb_cyc_i && wb_stb_i && !ack;
   wire wr = req && wb_we_i;
   wire hit_hdr = wb_adr_i == budget_pkg::OFF_CAP_HEADER;
   wire hit_sel = wb_adr_i == budget_pkg::OFF_SELECT;
   wire hit_rd = wb_adr_i == budget_pkg::OFF_READOUT;
   wire hit_unl = wb_adr_i == budget_pkg::OFF_UNLOCK;
   wire hit_lock = wb_adr_i == budget_pkg::OFF_HEADER_LOCK;
   wire [11:0] entry_off = wb_adr_i - budget_pkg::OFF_ENTRY_BASE;
   wire hit_entry = wb_adr_i >= budget_pkg::OFF_ENTRY_BASE && entry_off[11:2] < 10'(budget_pkg::ENTRY_COUNT)
      && entry_off[1:0] == 2'b00; // [R7]
   wire [3:0] entry_idx = hit_entry ? entry_off[5:2] : 4'hF;
   wire [31:0] entry_rd;
   wire [31:0] sel_data;
   wire [31:0] hdr_word = budget_cap_header;
   wire [31:0] wmask;
   wire [31:0] next_hdr = (hdr_word & ~wmask) | (wb_dat_i & wmask);

   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++) begin : gen_lane
         assign wmask[8*lane +: 8] = {8{wb_sel_i[lane]}};
      end
   endgenerate

   budget_entry_store #(
      .ENTRIES(budget_pkg::ENTRY_COUNT)
   ) u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .unlock_i(budget_entry_unlock),
      .wr_en_i(wr && hit_entry),
      .wr_idx_i(entry_idx),
      .wr_sel_i(wb_sel_i),
      .wr_data_i(wb_dat_i),
      .rd_sel_i(budget_entry_selector),
      .rd_data_o(entry_rd),
      .sel_data_o(sel_data)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         budget_cap_header <= budget_pkg::HEADER_RESET; // [R9] [R3]
      end else if (wr && hit_hdr && header_write_open) begin
         budget_cap_header <= next_hdr; // [R1] [R2] [R9]
      end
   end

   a_hdr_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      $past(rst_i) |-> budget_cap_header == budget_pkg::HEADER_RESET)
      else $error("header not zero after reset");
   a_id_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
      wr && hit_hdr && header_write_open && wb_sel_i[1:0] == 2'b11
      |=> budget_cap_header.capability_identifier == $past(wb_dat_i[15:0]))
      else $error("identifier write lost");
   a_link_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      wr && hit_hdr && header_write_open && wb_sel_i[3:2] == 2'b11
      |=> budget_cap_header.following_structure_link == $past(wb_dat_i[31:20]))
      else $error("link write lost");
   a_hdr_lane_keep: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      wr && hit_hdr && !wb_sel_i[0] |=> hdr_word[7:0] == $past(hdr_word[7:0]))
      else $error("disabled header lane written");
   a_ver_lane_keep: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
      wr && hit_hdr && !wb_sel_i[2] |=> budget_cap_header.structure_version == $past(hdr_word[19:16]))
      else $error("version changed without its lane");
   a_hdr_addr_only: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      !(wr && hit_hdr) |=> $stable(budget_cap_header))
      else $error("header changed without a header write");

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         budget_entry_selector <= budget_pkg::SELECT_RESET; // [R4]
      end else if (wr && hit_sel && wb_sel_i[0]) begin
         budget_entry_selector <= wb_dat_i[7:0]; // [R4]
      end
   end

   a_sel_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      $past(rst_i) |-> budget_entry_selector == budget_pkg::SELECT_RESET)
      else $error("selector not zero after reset");
   a_sel_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      !(wr && hit_sel && wb_sel_i[0]) |=> $stable(budget_entry_selector))
      else $error("selector changed without a selector write");

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         budget_entry_unlock <= 1'b0;
         header_write_open <= 1'b0;
      end else if (wr && wb_sel_i[0]) begin
         if (hit_unl) begin
            budget_entry_unlock <= wb_dat_i[0];
         end
         if (hit_lock) begin
            header_write_open <= wb_dat_i[0];
         end
      end
   end

   a_lock_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      $past(rst_i) |-> !header_write_open && !budget_entry_unlock)
      else $error("write permissions open after reset");
   a_unlock_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      wr && hit_unl && wb_sel_i[0] |=> budget_entry_unlock == $past(wb_dat_i[0]))
      else $error("unlock write lost");
   a_lock_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      wr && hit_lock && wb_sel_i[0] |=> header_write_open == $past(wb_dat_i[0]))
      else $error("header lock write lost");

   always_comb begin
      rdata = 32'h0000_0000;
      if (hit_hdr) begin
         rdata = hdr_word;
      end else if (hit_sel) begin
         rdata = {24'h00_0000, budget_entry_selector};
      end else if (hit_rd) begin
         rdata = sel_data; // [R6]
      end else if (hit_entry) begin
         rdata = entry_rd;
      end else if (hit_unl) begin
         rdata = {31'h0000_0000, budget_entry_unlock};
      end else if (hit_lock) begin
         rdata = {31'h0000_0000, header_write_open};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack <= req;
         wb_dat_o <= req ? rdata : 32'h0000_0000;
      end
   end

   a_ack_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      $past(rst_i) |-> !ack && wb_dat_o == 32'h0000_0000)
      else $error("bus outputs busy after reset");
   a_rd_header: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
      req && !wb_we_i && hit_hdr |=> wb_dat_o == $past(hdr_word))
      else $error("header read wrong");
   a_rd_select: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      req && !wb_we_i && hit_sel |=> wb_dat_o == {24'h00_0000, $past(budget_entry_selector)})
      else $error("selector read wrong");
   a_rd_readout: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
      req && !wb_we_i && hit_rd |=> wb_dat_o == $past(sel_data))
      else $error("readout read wrong");
   a_rd_zero_high: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
      req && !wb_we_i && hit_rd && $past(budget_entry_selector) > 8'h09 |=> wb_dat_o == 32'h0000_0000)
      else $error("readout read nonzero for selector above nine");
   a_rd_entry: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      req && !wb_we_i && hit_entry |=> wb_dat_o == $past(entry_rd))
      else $error("entry read wrong");
   a_rd_unlock: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      req && !wb_we_i && hit_unl |=> wb_dat_o == {31'h0000_0000, $past(budget_entry_unlock)})
      else $error("unlock read wrong");
   a_rd_lock: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      req && !wb_we_i && hit_lock |=> wb_dat_o == {31'h0000_0000, $past(header_write_open)})
      else $error("header lock read wrong");
   a_rd_unmapped: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      req && !wb_we_i && !(hit_hdr || hit_sel || hit_rd || hit_entry || hit_unl || hit_lock)
      |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
      !ack |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside acknowledge");

   assign wb_ack_o = ack;
   assign budget_readout_o = sel_data;

   a_sel_zero_high: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
      $past(budget_entry_selector) > 8'h09 |-> sel_data == 32'h0000_0000)
      else $error("readout nonzero for selector above nine");
   a_hdr_locked: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      !$past(header_write_open) |-> $stable(budget_cap_header))
      else $error("header changed while locked");
   a_sel_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      wr && hit_sel && wb_sel_i[0] |=> budget_entry_selector == $past(wb_dat_i[7:0]))
      else $error("selector write lost");
   a_readout_ro: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
      wr && hit_rd && $stable(budget_entry_selector) |=> ##1 $stable(sel_data))
      else $error("readout changed by write");
   a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      req |=> ack ##1 !ack)
      else $error("ack not single cycle");
   a_hdr_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
      wr && hit_hdr && header_write_open && wb_sel_i == 4'hF |=> hdr_word == $past(wb_dat_i))
      else $error("header write lost");
   a_ver_field: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
      wr && hit_hdr && header_write_open && wb_sel_i[2]
      |=> budget_cap_header.structure_version == $past(wb_dat_i[19:16]))
      else $error("version field wrong");
   a_entry_lock: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      budget_entry_selector <= 8'h09 && !budget_entry_unlock && $stable(budget_entry_selector) ##1
      $stable(budget_entry_selector) && !budget_entry_unlock |=> $stable(sel_data))
      else $error("entry changed while locked");
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   budget_pkg::wb_req_s req = '0;
   logic [31:0] wb_dat_o;
   logic [31:0] budget_readout_o;
   logic [31:0] rd;
   logic wb_ack_o;
   int miscompares = 0;
   int check_count = 0;

   power_budget_capability_regs i_power_budget_capability_regs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(req.cyc),
      .wb_stb_i(req.stb),
      .wb_we_i(req.we),
      .wb_sel_i(req.sel),
      .wb_adr_i(req.adr),
      .wb_dat_i(req.dat),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .budget_readout_o(budget_readout_o)
   );

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic single cycle: hold until ack, take data at that edge, idle one cycle
   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
      int n;
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      if (wb_ack_o !== 1'b1) begin
         miscompares++;
         finish_test();
      end else begin
         rd = wb_dat_o;
         req <= '0;
         @(posedge clk_i);
      end
   endtask

   function automatic logic [31:0] ev(input int i);
      return {8'(i + 1), 24'hC35A96};
   endfunction

   // Selector write with reserved bits set, then readback of selector and readout
   task automatic sel_chk(input int s);
      logic [31:0] exp;
      exp = (s < 10) ? ev(s) : 32'h0000_0000;
      wb(1'b1, budget_pkg::OFF_SELECT, {24'hFFFFFF, 8'(s)});
      wb(1'b0, budget_pkg::OFF_SELECT, 32'h0);
      chk(rd, {24'h000000, 8'(s)});
      wb(1'b0, budget_pkg::OFF_READOUT, 32'h0);
      chk(rd, exp);
      chk(budget_readout_o, exp);
   endtask

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         wb(1'b0, 12'h280 + 12'(4 * k), 32'h0);
         chk(rd, 32'h0000_0000);
      end
      wb(1'b1, budget_pkg::OFF_CAP_HEADER, 32'hABC1_0004);
      wb(1'b0, budget_pkg::OFF_CAP_HEADER, 32'h0);
      chk(rd, 32'h0000_0000);
      wb(1'b1, budget_pkg::OFF_HEADER_LOCK, 32'h0000_0001);
      wb(1'b1, budget_pkg::OFF_CAP_HEADER, {12'hABC, budget_pkg::CAP_VERSION_ONE, budget_pkg::CAP_ID_POWER});
      wb(1'b0, budget_pkg::OFF_CAP_HEADER, 32'h0);
      chk(rd, {12'hABC, budget_pkg::CAP_VERSION_ONE, budget_pkg::CAP_ID_POWER});
      wb(1'b1, budget_pkg::OFF_HEADER_LOCK, 32'h0);
      wb(1'b1, budget_pkg::OFF_CAP_HEADER, 32'h0);
      wb(1'b0, budget_pkg::OFF_CAP_HEADER, 32'h0);
      chk(rd, {12'hABC, budget_pkg::CAP_VERSION_ONE, budget_pkg::CAP_ID_POWER});
      wb(1'b1, budget_pkg::OFF_UNLOCK, 32'h0000_0001);
      for (int i = 0; i < 10; i++) begin
         wb(1'b1, budget_pkg::OFF_ENTRY_BASE + 12'(4 * i), ev(i));
      end
      wb(1'b1, budget_pkg::OFF_UNLOCK, 32'h0);
      wb(1'b1, budget_pkg::OFF_ENTRY_BASE + 12'h004, 32'h0);
      wb(1'b0, budget_pkg::OFF_ENTRY_BASE + 12'h004, 32'h0);
      chk(rd, ev(1));
      for (int s = 0; s < 12; s++) begin
         sel_chk(s);
      end
      sel_chk(31);
      sel_chk(255);
      sel_chk(3);
      wb(1'b1, budget_pkg::OFF_READOUT, 32'hFFFF_FFFF);
      wb(1'b0, budget_pkg::OFF_READOUT, 32'h0);
      chk(rd, ev(3));
      chk(budget_readout_o, ev(3));
      wb(1'b0, 12'h3FC, 32'h0);
      chk(rd, 32'h0000_0000);
      finish_test();
   end
endmodule
